//--- rtl/rss_pkg.sv
// Purpose: Constants and types shared by the reset source sequencer.
// Assumes: pclk at 250 MHz; APB with 32-bit data, one aligned word per register.
// Notes:   Cycle counts derive from the printed times and the clock rate.
//
// Notes on behaviour
// - Hardware reset pin low holds the whole device in reset until released.
// - Each reset source resets only its own set of circuits.
// - Soft reset leaves software-reset-exempt configuration bits untouched.
// - Ready bit reads 0 until hardware reset completes, then 1.
// - Reset pin has an internal pull-up and may float.
// - After power-up reset, ready sets after about 22 ms.
// - After a wake-up write, ready sets within 2 ms.
// - Bit 0 of hardware config starts soft reset, self-clears after about 2 us.
// - Bit 10 of power control resets PHY, self-clears after about 100 us.
// - Bit 15 of PHY basic control resets PHY, self-clears when done.
// - Power-up, hardware or soft reset starts an EEPROM probe.
// - Any write to the wake-up test register returns to full operation.
// - Entering a sleep state clears the ready bit.
package rss_pkg;

  localparam int unsigned CLK_KHZ        = 250_000;
  localparam int unsigned HW_READY_MS    = 22;
  localparam int unsigned WAKE_READY_MS  = 2;
  localparam int unsigned SOFT_RESET_BIT_US        = 2;
  localparam int unsigned PHY_RST_US     = 100;
  localparam int unsigned HW_READY_CYC   = HW_READY_MS * CLK_KHZ;
  localparam int unsigned WAKE_READY_CYC = WAKE_READY_MS * CLK_KHZ;
  localparam int unsigned SOFT_RESET_BIT_CYC       = SOFT_RESET_BIT_US * CLK_KHZ / 1000;
  localparam int unsigned PHY_RST_CYC    = PHY_RST_US * CLK_KHZ / 1000;

  localparam logic [11:0] OFF_HARDWARE_CONFIG_REG    = 12'h000;
  localparam logic [11:0] OFF_POWER_MGMT_CONTROL_REG  = 12'h004;
  localparam logic [11:0] OFF_WAKE_TEST = 12'h008;
  localparam logic [11:0] OFF_EEPROM_COMMAND_REG   = 12'h00C;
  localparam logic [11:0] OFF_PHY_BCR   = 12'h010;
  localparam logic [11:0] OFF_STATUS    = 12'h014;

  localparam int unsigned HARDWARE_CONFIG_REG_SOFT_RESET_BIT_BIT   = 0;
  localparam int unsigned HARDWARE_CONFIG_REG_EXEMPT_LSB = 4;
  localparam int unsigned HARDWARE_CONFIG_REG_PLAIN_LSB  = 8;
  localparam int unsigned PMT_READY_BIT     = 0;
  localparam int unsigned PMT_PHY_RST_BIT   = 10;
  localparam int unsigned PMT_MODE_LSB      = 12;
  localparam int unsigned E2P_BUSY_BIT      = 31;
  localparam int unsigned PHY_BCR_RST_BIT   = 15;

  localparam logic [3:0]  HARDWARE_CONFIG_REG_EXEMPT_RST = 4'h0;
  localparam logic [7:0]  HARDWARE_CONFIG_REG_PLAIN_RST  = 8'h00;
  // Arbitrary fixed pattern returned by the wake-up test register
  localparam logic [31:0] WAKE_TEST_PATTERN = 32'h0F1E_2D3C;

  localparam logic [1:0] PM_D0 = 2'b00;
  localparam logic [1:0] PM_D1 = 2'b01;
  localparam logic [1:0] PM_D2 = 2'b10;

  typedef enum logic [2:0] {
    RSS_ST_HWRST = 3'b000,
    RSS_ST_PWRUP = 3'b001,
    RSS_ST_RUN   = 3'b010,
    RSS_ST_SLEEP = 3'b011,
    RSS_ST_WAKE  = 3'b100
  } rss_state_t;

endpackage

//--- rtl/rss_timer.sv
// Purpose: Down-counting interval timer with a one-cycle done pulse.
// Assumes: load is a single-cycle request and clear a level held while the pin is low; clear wins over load.
// Notes:   busy is high for exactly the loaded number of cycles.
`timescale 1ns/1ps
`default_nettype none
module rss_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clear,
  input  wire logic        load,
  input  wire logic [31:0] cycles,
  output logic             busy,
  output logic             done
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        done_reg;
  logic        done_next;

  always_comb begin
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (clear) begin
      cnt_next = 32'h0000_0000;
    end else if (load) begin
      cnt_next = cycles;
    end else if (cnt_reg != 32'h0000_0000) begin
      cnt_next  = cnt_reg - 32'h0000_0001;
      done_next = (cnt_reg == 32'h0000_0001);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= 32'h0000_0000;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign busy = (cnt_reg != 32'h0000_0000);
  assign done = done_reg;

endmodule
`default_nettype wire

//--- rtl/rss_scope.sv
// Purpose: Maps active reset sources onto the per-circuit reset lines.
// Assumes: Source inputs are synchronous levels from the sequencer.
// Notes:   Outputs are registered so the reset lines never glitch.
`timescale 1ns/1ps
`default_nettype none
module rss_scope (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic hw_active,
  input  wire logic soft_active,
  input  wire logic phy_active,
  output logic      rst_pll_n,
  output logic      rst_hbi_n,
  output logic      rst_soft_reset_exempt_n,
  output logic      rst_mil_n,
  output logic      rst_mac_n,
  output logic      rst_phy_n
);

  logic [5:0] line_reg;
  logic [5:0] line_next;

  always_comb begin
    line_next[0] = ~hw_active;
    line_next[1] = ~(hw_active | soft_active);
    line_next[2] = ~hw_active;
    line_next[3] = ~(hw_active | soft_active);
    line_next[4] = ~(hw_active | soft_active);
    line_next[5] = ~(hw_active | phy_active);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_reg <= 6'h00;
    end else begin
      line_reg <= line_next;
    end
  end

  assign rst_pll_n  = line_reg[0];
  assign rst_hbi_n  = line_reg[1];
  assign rst_soft_reset_exempt_n = line_reg[2];
  assign rst_mil_n  = line_reg[3];
  assign rst_mac_n  = line_reg[4];
  assign rst_phy_n  = line_reg[5];

endmodule
`default_nettype wire

//--- rtl/rss_reset_sequencer.sv
// Purpose: Reset source sequencer with APB register access.
// Assumes: hw_reset_n_pin is synchronous to pclk; the pad pull-up keeps it high
//          when left open, so an unconnected pin reads as released.
// Notes:   presetn is the internal power-up reset; zero-wait APB slave.
`timescale 1ns/1ps
`default_nettype none
module rss_reset_sequencer #(
  parameter int unsigned HW_READY_CYCLES   = rss_pkg::HW_READY_CYC,
  parameter int unsigned WAKE_READY_CYCLES = rss_pkg::WAKE_READY_CYC,
  parameter int unsigned PHY_RST_CYCLES    = rss_pkg::PHY_RST_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hw_reset_n_pin,
  input  wire logic        eeprom_probe_done,
  output logic             eeprom_probe_start,
  output logic             eeprom_ctrl_busy_flag,
  output logic             strap_latch,
  output logic             ready,
  output logic [1:0]       pm_mode,
  output logic             rst_pll_n,
  output logic             rst_hbi_n,
  output logic             rst_soft_reset_exempt_n,
  output logic             rst_mil_n,
  output logic             rst_mac_n,
  output logic             rst_phy_n
);

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == rss_pkg::OFF_HARDWARE_CONFIG_REG)   || (a == rss_pkg::OFF_POWER_MGMT_CONTROL_REG) ||
                  (a == rss_pkg::OFF_WAKE_TEST) || (a == rss_pkg::OFF_EEPROM_COMMAND_REG) ||
                  (a == rss_pkg::OFF_PHY_BCR)   || (a == rss_pkg::OFF_STATUS);
  endfunction

  rss_pkg::rss_state_t state_reg;
  rss_pkg::rss_state_t state_next;
  logic        ready_reg;
  logic        ready_next;
  logic        soft_reset_bit_reg;
  logic        soft_reset_bit_next;
  logic [3:0]  cfg_exempt_reg;
  logic [3:0]  cfg_exempt_next;
  logic [7:0]  cfg_plain_reg;
  logic [7:0]  cfg_plain_next;
  logic [1:0]  pm_reg;
  logic [1:0]  pm_next;
  logic        phy_rst_reg;
  logic        phy_rst_next;
  logic        bcr_rst_reg;
  logic        bcr_rst_next;
  logic        e2p_busy_reg;
  logic        e2p_busy_next;
  logic        probe_reg;
  logic        probe_next;
  logic        strap_reg;
  logic        strap_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  logic        acc_wr;
  logic        wr_hardware_config_reg;
  logic        wr_pmt;
  logic        wr_wake;
  logic        wr_bcr;
  logic        wr_allowed;
  logic        ready_clear;
  logic        ready_load;
  logic [31:0] ready_cycles;
  logic        ready_busy;
  logic        ready_done;
  logic        soft_reset_bit_load;
  logic        soft_reset_bit_busy;
  logic        soft_reset_bit_done;
  logic        phy_load;
  logic        phy_busy;
  logic        phy_done;
  logic        hw_active;

  // Zero-wait slave: every access phase completes at once
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped(paddr);
  assign acc_wr  = psel & penable & pwrite;

  // Only the wake write is honoured while not ready or during soft reset
  assign wr_allowed = ready_reg & ~soft_reset_bit_busy;
  assign wr_wake    = acc_wr & (paddr == rss_pkg::OFF_WAKE_TEST);
  assign wr_hardware_config_reg  = acc_wr & wr_allowed & (paddr == rss_pkg::OFF_HARDWARE_CONFIG_REG);
  assign wr_pmt     = acc_wr & wr_allowed & (paddr == rss_pkg::OFF_POWER_MGMT_CONTROL_REG);
  assign wr_bcr     = acc_wr & wr_allowed & (paddr == rss_pkg::OFF_PHY_BCR);

  // Pad pull-up holds the pin released when open, so high means no reset
  assign hw_active = ~hw_reset_n_pin | (state_reg == rss_pkg::RSS_ST_HWRST);
  assign ready_clear = ~hw_reset_n_pin;

  always_comb begin
    state_next          = state_reg;
    ready_next          = ready_reg;
    soft_reset_bit_next = soft_reset_bit_reg;
    cfg_exempt_next     = cfg_exempt_reg;
    cfg_plain_next      = cfg_plain_reg;
    pm_next             = pm_reg;
    phy_rst_next        = phy_rst_reg;
    bcr_rst_next        = bcr_rst_reg;
    e2p_busy_next       = e2p_busy_reg;
    probe_next          = 1'b0;
    strap_next          = 1'b0;
    ready_load          = 1'b0;
    ready_cycles        = HW_READY_CYCLES;
    soft_reset_bit_load           = 1'b0;
    phy_load            = 1'b0;
    if (!hw_reset_n_pin) begin
      // Hardware reset clears everything, exempt bits included
      state_next          = rss_pkg::RSS_ST_HWRST;
      ready_next          = 1'b0;
      soft_reset_bit_next = 1'b0;
      cfg_exempt_next     = rss_pkg::HARDWARE_CONFIG_REG_EXEMPT_RST;
      cfg_plain_next      = rss_pkg::HARDWARE_CONFIG_REG_PLAIN_RST;
      pm_next             = rss_pkg::PM_D0;
      phy_rst_next        = 1'b0;
      bcr_rst_next        = 1'b0;
      e2p_busy_next       = 1'b0;
    end else begin
      case (state_reg)
        rss_pkg::RSS_ST_HWRST: begin
          state_next    = rss_pkg::RSS_ST_PWRUP;
          strap_next    = 1'b1;
          ready_load    = 1'b1;
          ready_cycles  = HW_READY_CYCLES;
        end
        rss_pkg::RSS_ST_PWRUP: begin
          if (ready_done) begin
            ready_next = 1'b1;
            state_next = rss_pkg::RSS_ST_RUN;
          end
        end
        rss_pkg::RSS_ST_RUN: begin
          if (pm_reg != rss_pkg::PM_D0) begin
            ready_next = 1'b0;
            state_next = rss_pkg::RSS_ST_SLEEP;
          end
        end
        rss_pkg::RSS_ST_SLEEP: begin
          if (wr_wake) begin
            pm_next      = rss_pkg::PM_D0;
            ready_load   = 1'b1;
            ready_cycles = WAKE_READY_CYCLES;
            state_next   = rss_pkg::RSS_ST_WAKE;
          end
        end
        rss_pkg::RSS_ST_WAKE: begin
          if (ready_done) begin
            ready_next = 1'b1;
            state_next = rss_pkg::RSS_ST_RUN;
          end
        end
        default: begin
          state_next = rss_pkg::RSS_ST_HWRST;
        end
      endcase

      // Clears first so that a same-cycle set below wins
      if (eeprom_probe_done) begin
        e2p_busy_next = 1'b0;
      end
      if (soft_reset_bit_done) begin
        soft_reset_bit_next = 1'b0;
      end
      if (phy_done) begin
        phy_rst_next = 1'b0;
        bcr_rst_next = 1'b0;
      end

      // Probe after power-up, hardware reset release or soft reset end
      if ((state_reg == rss_pkg::RSS_ST_HWRST) || soft_reset_bit_done) begin
        probe_next    = 1'b1;
        e2p_busy_next = 1'b1;
      end

      if (wr_hardware_config_reg) begin
        cfg_exempt_next = pwdata[rss_pkg::HARDWARE_CONFIG_REG_EXEMPT_LSB +: 4];
        if (pwdata[rss_pkg::HARDWARE_CONFIG_REG_SOFT_RESET_BIT_BIT]) begin
          soft_reset_bit_next = 1'b1;
          soft_reset_bit_load           = 1'b1;
          cfg_plain_next      = rss_pkg::HARDWARE_CONFIG_REG_PLAIN_RST;
          pm_next             = rss_pkg::PM_D0;
          // Exempt field keeps its old value through soft reset
          cfg_exempt_next     = cfg_exempt_reg;
        end else begin
          cfg_plain_next = pwdata[rss_pkg::HARDWARE_CONFIG_REG_PLAIN_LSB +: 8];
        end
      end
      if (wr_pmt) begin
        pm_next = pwdata[rss_pkg::PMT_MODE_LSB +: 2];
        if (pwdata[rss_pkg::PMT_PHY_RST_BIT]) begin
          phy_rst_next = 1'b1;
          phy_load     = ~phy_busy;
        end
      end
      if (wr_bcr && pwdata[rss_pkg::PHY_BCR_RST_BIT]) begin
        bcr_rst_next = 1'b1;
        phy_load     = ~phy_busy;
      end
    end
  end

  always_comb begin
    prdata_next = prdata_reg;
    // Read data is captured in the setup cycle and shown in the access phase
    if (psel && !penable) begin
      prdata_next = 32'h0000_0000;
      if (paddr == rss_pkg::OFF_HARDWARE_CONFIG_REG) begin
        prdata_next[rss_pkg::HARDWARE_CONFIG_REG_SOFT_RESET_BIT_BIT]        = soft_reset_bit_reg;
        prdata_next[rss_pkg::HARDWARE_CONFIG_REG_EXEMPT_LSB +: 4] = cfg_exempt_reg;
        prdata_next[rss_pkg::HARDWARE_CONFIG_REG_PLAIN_LSB +: 8]  = cfg_plain_reg;
      end else if (paddr == rss_pkg::OFF_POWER_MGMT_CONTROL_REG) begin
        prdata_next[rss_pkg::PMT_READY_BIT]     = ready_reg;
        prdata_next[rss_pkg::PMT_PHY_RST_BIT]   = phy_rst_reg;
        prdata_next[rss_pkg::PMT_MODE_LSB +: 2] = pm_reg;
      end else if (paddr == rss_pkg::OFF_WAKE_TEST) begin
        prdata_next = rss_pkg::WAKE_TEST_PATTERN;
      end else if (paddr == rss_pkg::OFF_EEPROM_COMMAND_REG) begin
        prdata_next[rss_pkg::E2P_BUSY_BIT] = e2p_busy_reg;
      end else if (paddr == rss_pkg::OFF_PHY_BCR) begin
        prdata_next[rss_pkg::PHY_BCR_RST_BIT] = bcr_rst_reg;
      end else if (paddr == rss_pkg::OFF_STATUS) begin
        prdata_next[2:0] = state_reg;
        prdata_next[3]   = soft_reset_bit_busy;
        prdata_next[4]   = phy_busy;
        prdata_next[5]   = ready_busy;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg          <= rss_pkg::RSS_ST_HWRST;
      ready_reg          <= 1'b0;
      soft_reset_bit_reg <= 1'b0;
      cfg_exempt_reg     <= rss_pkg::HARDWARE_CONFIG_REG_EXEMPT_RST;
      cfg_plain_reg      <= rss_pkg::HARDWARE_CONFIG_REG_PLAIN_RST;
      pm_reg             <= rss_pkg::PM_D0;
      phy_rst_reg        <= 1'b0;
      bcr_rst_reg        <= 1'b0;
      e2p_busy_reg       <= 1'b0;
      probe_reg          <= 1'b0;
      strap_reg          <= 1'b0;
      prdata_reg         <= 32'h0000_0000;
    end else begin
      state_reg          <= state_next;
      ready_reg          <= ready_next;
      soft_reset_bit_reg <= soft_reset_bit_next;
      cfg_exempt_reg     <= cfg_exempt_next;
      cfg_plain_reg      <= cfg_plain_next;
      pm_reg             <= pm_next;
      phy_rst_reg        <= phy_rst_next;
      bcr_rst_reg        <= bcr_rst_next;
      e2p_busy_reg       <= e2p_busy_next;
      probe_reg          <= probe_next;
      strap_reg          <= strap_next;
      prdata_reg         <= prdata_next;
    end
  end

  rss_timer u_ready_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (ready_clear),
    .load    (ready_load),
    .cycles  (ready_cycles),
    .busy    (ready_busy),
    .done    (ready_done)
  );

  rss_timer u_soft_reset_bit_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (ready_clear),
    .load    (soft_reset_bit_load),
    .cycles  (rss_pkg::SOFT_RESET_BIT_CYC),
    .busy    (soft_reset_bit_busy),
    .done    (soft_reset_bit_done)
  );

  rss_timer u_phy_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (ready_clear),
    .load    (phy_load),
    .cycles  (PHY_RST_CYCLES),
    .busy    (phy_busy),
    .done    (phy_done)
  );

  rss_scope u_scope (
    .pclk        (pclk),
    .presetn     (presetn),
    .hw_active   (hw_active),
    .soft_active (soft_reset_bit_busy),
    .phy_active  (phy_busy),
    .rst_pll_n   (rst_pll_n),
    .rst_hbi_n   (rst_hbi_n),
    .rst_soft_reset_exempt_n  (rst_soft_reset_exempt_n),
    .rst_mil_n   (rst_mil_n),
    .rst_mac_n   (rst_mac_n),
    .rst_phy_n   (rst_phy_n)
  );

  assign prdata                = prdata_reg;
  assign eeprom_probe_start    = probe_reg;
  assign eeprom_ctrl_busy_flag = e2p_busy_reg;
  assign strap_latch           = strap_reg;
  assign ready                 = ready_reg;
  assign pm_mode               = pm_reg;

endmodule
`default_nettype wire

//--- testbench/rss_reset_sequencer_sva.sv
// Purpose: Port-level assertions for the reset source sequencer.
// Assumes: One clock domain; presetn is the power-up reset.
// Notes:   Soft reset length is the fixed 500-cycle window.
`timescale 1ns/1ps
`default_nettype none
module rss_reset_sequencer_sva #(
  parameter int unsigned HW_READY_CYCLES   = 50,
  parameter int unsigned WAKE_READY_CYCLES = 20,
  parameter int unsigned PHY_RST_CYCLES    = 30
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        hw_reset_n_pin,
  input wire logic        eeprom_probe_start,
  input wire logic        eeprom_ctrl_busy_flag,
  input wire logic        ready,
  input wire logic [1:0]  pm_mode,
  input wire logic        rst_pll_n,
  input wire logic        rst_hbi_n,
  input wire logic        rst_soft_reset_exempt_n,
  input wire logic        rst_mil_n,
  input wire logic        rst_mac_n,
  input wire logic        rst_phy_n
);
  localparam int HW_LO = HW_READY_CYCLES - 4;
  localparam int HW_HI = HW_READY_CYCLES + 4;
  localparam int WK_HI = WAKE_READY_CYCLES + 6;
  int unsigned soft_cnt;
  int unsigned phy_cnt;
  logic        wr;
  assign wr = psel && penable && pwrite;
  // Count cycles of a soft or PHY reset that runs without hardware reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_cnt <= 0;
      phy_cnt  <= 0;
    end else begin
      soft_cnt <= (rst_hbi_n || !rst_pll_n) ? 0 : soft_cnt + 1;
      phy_cnt  <= (rst_phy_n || !rst_pll_n) ? 0 : phy_cnt + 1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pin_resets_all: assert property (!hw_reset_n_pin |-> ##[1:2] (!rst_pll_n && !rst_hbi_n && !rst_phy_n && !ready))
    else $error("pin reset left a circuit running");
  a_soft_reset_exempt_hw_only: assert property (rst_soft_reset_exempt_n == rst_pll_n)
    else $error("exempt registers reset apart from hardware reset");
  a_soft_group: assert property (rst_hbi_n == rst_mil_n && rst_mil_n == rst_mac_n)
    else $error("soft reset group split");
  a_scope_exclusive: assert property (rst_pll_n |-> rst_phy_n || rst_hbi_n)
    else $error("soft and PHY reset overlap");
  a_ready_hw_time: assert property ($rose(rst_pll_n) |-> !ready ##[HW_LO:HW_HI] ready)
    else $error("ready not set in time after hardware reset");
  a_soft_reset_bit_length: assert property ($rose(rst_hbi_n) && $past(rst_pll_n) |-> soft_cnt inside {[495:505]})
    else $error("soft reset length wrong");
  a_phy_length: assert property ($rose(rst_phy_n) && $past(rst_pll_n)
    |-> phy_cnt inside {[PHY_RST_CYCLES - 1:PHY_RST_CYCLES + 2]})
    else $error("PHY reset length wrong");
  a_sleep_clear: assert property (wr && paddr == rss_pkg::OFF_POWER_MGMT_CONTROL_REG && pwdata[13:12] != 2'b00 && ready && rst_hbi_n
    |-> ##[1:2] !ready)
    else $error("ready not cleared on sleep");
  a_wake_ready: assert property (wr && paddr == rss_pkg::OFF_WAKE_TEST && pm_mode != 2'b00 |-> ##[1:WK_HI] ready)
    else $error("ready late after wake write");
  a_probe_busy: assert property (eeprom_probe_start |-> ##[0:1] eeprom_ctrl_busy_flag)
    else $error("busy not set by probe");
  c_soft: cover property ($rose(rst_hbi_n) && rst_pll_n);
  c_phy: cover property ($rose(rst_phy_n) && rst_pll_n);
  c_sleep: cover property ($fell(ready) && rst_pll_n);
endmodule
bind rss_reset_sequencer rss_reset_sequencer_sva #(
  .HW_READY_CYCLES(HW_READY_CYCLES), .WAKE_READY_CYCLES(WAKE_READY_CYCLES), .PHY_RST_CYCLES(PHY_RST_CYCLES)
) u_sva (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .hw_reset_n_pin(hw_reset_n_pin), .eeprom_probe_start(eeprom_probe_start),
  .eeprom_ctrl_busy_flag(eeprom_ctrl_busy_flag), .ready(ready), .pm_mode(pm_mode), .rst_pll_n(rst_pll_n),
  .rst_hbi_n(rst_hbi_n), .rst_soft_reset_exempt_n(rst_soft_reset_exempt_n), .rst_mil_n(rst_mil_n), .rst_mac_n(rst_mac_n),
  .rst_phy_n(rst_phy_n)
);
`default_nettype wire

//--- testbench/rss_eeprom_model.sv
// Purpose: EEPROM controller stand-in that answers a probe request.
// Assumes: delay is set by the bench, short or long.
// Notes:   done is a one-cycle pulse delay + 2 cycles after start.
`timescale 1ns/1ps
`default_nettype none
module rss_eeprom_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [15:0] delay,
  output logic             done
);
  int cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 0;
      done <= 1'b0;
    end else begin
      done <= (cnt == 1);
      if (start) begin
        cnt <= delay + 1;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/rss_reset_sequencer_tb.sv
// Purpose: Self-checking bench for the reset source sequencer.
// Assumes: Shortened timer parameters; zero-wait APB slave.
// Notes:   The reset pin is a pulled-up wire that the bench can pull low.
`timescale 1ns/1ps
`default_nettype none
module rss_reset_sequencer_tb;
  localparam int HWC = 50;
  localparam int WKC = 20;
  localparam int PHC = 30;
  localparam int SRC = 500;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin_low = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, m_cfg;
  logic        pready, pslverr, er, done, start, busy, strap, ready;
  logic        r_pll, r_hbi, r_soft_reset_exempt, r_mil, r_mac, r_phy;
  logic [1:0]  pm_mode;
  logic [15:0] ee_dly = 16'h0064;
  tri1         pin_w;
  int          fails = 0, cmp_count = 0, cyc = 0, n_strap = 0, n_probe = 0;
  assign pin_w = pin_low ? 1'b0 : 1'bz;
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (strap) n_strap <= n_strap + 1;
    if (start) n_probe <= n_probe + 1;
  end
  rss_reset_sequencer #(.HW_READY_CYCLES(HWC), .WAKE_READY_CYCLES(WKC), .PHY_RST_CYCLES(PHC)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_reset_n_pin(pin_w),
    .eeprom_probe_done(done), .eeprom_probe_start(start), .eeprom_ctrl_busy_flag(busy), .strap_latch(strap),
    .ready(ready), .pm_mode(pm_mode), .rst_pll_n(r_pll), .rst_hbi_n(r_hbi), .rst_soft_reset_exempt_n(r_soft_reset_exempt),
    .rst_mil_n(r_mil), .rst_mac_n(r_mac), .rst_phy_n(r_phy));
  rss_eeprom_model u_ee (.pclk(pclk), .presetn(presetn), .start(start), .delay(ee_dly), .done(done));
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 16) begin
        chk("pready wait", 0, 1);
        results();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic poll(input logic [11:0] a, input int b, input logic v, input int lim, output int took);
    int t0;
    t0 = cyc;
    apb(1'b0, a, 32'h0);
    while (rd[b] !== v) begin
      if (cyc - t0 > lim) begin
        chk("poll bound", 0, 1);
        results();
      end
      apb(1'b0, a, 32'h0);
    end
    took = cyc - t0;
  endtask
  initial begin
    #400000;
    chk("watchdog", 0, 1);
    results();
  end
  initial begin
    int t, sd;
    logic [31:0] v;
    sd = $urandom(48504);
    ee_dly = 16'h0050 + 16'($urandom % 40);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, rss_pkg::OFF_POWER_MGMT_CONTROL_REG, 32'h0);
    chk("ready early", rd[0], 1'b0);
    poll(rss_pkg::OFF_POWER_MGMT_CONTROL_REG, 0, 1'b1, HWC + 20, t);
    chk("ready time", t > HWC - 10, 1'b1);
    apb(1'b0, rss_pkg::OFF_STATUS, 32'h0);
    chk("status run", rd[5:0], 6'h02);
    apb(1'b0, rss_pkg::OFF_EEPROM_COMMAND_REG, 32'h0);
    chk("probe busy", rd[31], 1'b1);
    chk("probe busy pin", busy, 1'b1);
    poll(rss_pkg::OFF_EEPROM_COMMAND_REG, 31, 1'b0, 150, t);
    chk("strap once", n_strap, 1);
    apb(1'b0, rss_pkg::OFF_WAKE_TEST, 32'h0);
    chk("wake pattern", rd, rss_pkg::WAKE_TEST_PATTERN);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped err", er, 1'b1);
    m_cfg = $urandom & 32'h0000FFF0;
    apb(1'b1, rss_pkg::OFF_HARDWARE_CONFIG_REG, m_cfg);
    apb(1'b0, rss_pkg::OFF_HARDWARE_CONFIG_REG, 32'h0);
    chk("cfg rw", rd, m_cfg);
    $display("test powerup done");
    ee_dly <= 16'h0003;
    apb(1'b1, rss_pkg::OFF_HARDWARE_CONFIG_REG, m_cfg | 32'h1);
    m_cfg = m_cfg & 32'h000000F0;
    @(posedge pclk);
    chk("soft scope", {r_pll, r_soft_reset_exempt, r_hbi, r_mil, r_mac, r_phy}, 6'b110001);
    poll(rss_pkg::OFF_HARDWARE_CONFIG_REG, 0, 1'b0, SRC + 30, t);
    chk("soft length", t > SRC - 20, 1'b1);
    apb(1'b0, rss_pkg::OFF_HARDWARE_CONFIG_REG, 32'h0);
    chk("cfg exempt kept", rd, m_cfg);
    chk("probe count", n_probe, 2);
    chk("strap kept", n_strap, 1);
    $display("test soft reset done");
    for (int i = 0; i < 2; i++) begin
      v = i ? 32'h8000 : 32'h0400;
      apb(1'b1, i ? rss_pkg::OFF_PHY_BCR : rss_pkg::OFF_POWER_MGMT_CONTROL_REG, v);
      @(posedge pclk);
      chk("phy scope", {r_pll, r_hbi, r_phy}, 3'b110);
      poll(i ? rss_pkg::OFF_PHY_BCR : rss_pkg::OFF_POWER_MGMT_CONTROL_REG, i ? 15 : 10, 1'b0, PHC + 20, t);
      chk("phy length", t > PHC - 12, 1'b1);
    end
    $display("test phy reset done");
    for (int m = 1; m < 3; m++) begin
      apb(1'b1, rss_pkg::OFF_POWER_MGMT_CONTROL_REG, 32'(m) << 12);
      repeat (2) @(posedge pclk);
      apb(1'b0, rss_pkg::OFF_POWER_MGMT_CONTROL_REG, 32'h0);
      chk("sleep pmt", rd & 32'h00003001, 32'(m) << 12);
      apb(1'b1, rss_pkg::OFF_HARDWARE_CONFIG_REG, 32'h0000FF00);
      apb(1'b1, rss_pkg::OFF_WAKE_TEST, $urandom);
      poll(rss_pkg::OFF_POWER_MGMT_CONTROL_REG, 0, 1'b1, WKC + 12, t);
      chk("wake mode", pm_mode, 2'b00);
      apb(1'b0, rss_pkg::OFF_HARDWARE_CONFIG_REG, 32'h0);
      chk("cfg while asleep", rd, m_cfg);
    end
    $display("test sleep wake done");
    pin_low <= 1'b1;
    repeat (2 + $urandom % 6) @(posedge pclk);
    chk("pin scope", {r_pll, r_soft_reset_exempt, r_hbi, r_phy, ready}, 5'b00000);
    pin_low <= 1'b0;
    poll(rss_pkg::OFF_POWER_MGMT_CONTROL_REG, 0, 1'b1, HWC + 20, t);
    chk("strap again", n_strap, 2);
    apb(1'b0, rss_pkg::OFF_HARDWARE_CONFIG_REG, 32'h0);
    chk("cfg cleared", rd, 32'h0);
    $display("test pin reset done");
    results();
  end
endmodule
`default_nettype wire
